// file: tcr_regs.vh
/*
  register offsets, field positions, reset values and limit codes of the
  thermal configuration register pair.
  assumes it is included by bare name from the design file.
*/
`ifndef TCR_REGS_VH
`define TCR_REGS_VH

`define TCR_FMT_PIN_ADDR 8'h7C
`define TCR_MUX_ATT_ADDR 8'h7D
`define TCR_FMT_PIN_RESET 8'h05
`define TCR_MUX_ATT_RESET 8'h00

`define TCR_FMT_BIT 0
`define TCR_OFSR_BIT 1
`define TCR_ALERTF_LO 2
`define TCR_CPU_EN_BIT 4
`define TCR_REMA_EN_BIT 5
`define TCR_LOCAL_EN_BIT 6
`define TCR_REMB_EN_BIT 7
`define TCR_TACHF_LO 0
`define TCR_GDIS_BIT 2
`define TCR_BYP_LO 3

`define TCR_FN_ALERT_A 2'b00
`define TCR_FN_OVT_A 2'b01
`define TCR_FN_GPIO_A 2'b10
`define TCR_FN_TACH_B 2'b00
`define TCR_FN_OVT_B 2'b01
`define TCR_FN_ALERT_B 2'b10

`define TCR_DIS_OFS64 8'h00
`define TCR_DIS_TWOS 8'h80
`define TCR_OFS64_BIAS 8'h40

`endif

// file: tcr_config_regs.v
/*
  two lockable configuration registers: temperature format, offset range,
  pin functions, overtemperature enables and attenuator bypass, plus the
  overtemperature decision they steer.
  assumes a byte register port from the serial slave, synchronous inputs,
  and raw temperature and limit codes from the measurement engines.
*/
// Operation
// - bit 0 picks two's complement (1) or offset-64 binary (0).
// - a format change reinterprets remote and local temperatures and limits at once; cpu stays two's.
// - bit 1 picks half-degree to +64 or one-degree to +127 offsets.
// - offset range touches remote and internal offsets only; cpu offset one-degree.
// - bits 3:2 choose alert pin: alert, overtemp, third gpio, reserved.
// - lock set makes both registers read-only; writes silently dropped.
// - bit 4 drives overtemp when cpu reading exceeds cpu control limit.
// - a disabled channel never drives the overtemp pin.
// - bit 5 drives overtemp when remote A exceeds its limit.
// - bit 6 drives overtemp when local exceeds its limit.
// - bit 7 drives overtemp when remote B exceeds its limit.
// - limit of -64 (offset-64) or -128 (two's) suppresses that channel.
// - cpu control limit of -128 suppresses the cpu comparison.
// - bits 1:0 choose tach pin: fan input four, overtemp, alert, reserved.
// - bit 2 disables overtemp output on every channel.
// - bits 7:3 bypass attenuators of five voltage channels, 0 to 2 V.
`timescale 1ns/100ps
`include "tcr_regs.vh"

module tcr_config_regs #(
  parameter ADDR_WIDTH = 8
) (
  input wire ref_clk,
  input wire rst_n,
  input wire [ADDR_WIDTH-1:0] regAddr,
  input wire [7:0] regWrData,
  input wire regWrEn,
  input wire regRdEn,
  output reg [7:0] regRdData,
  input wire configLock,
  input wire overtempPinBidir,
  input wire [7:0] remoteATemp,
  input wire [7:0] remoteALimit,
  input wire [7:0] localTemp,
  input wire [7:0] localLimit,
  input wire [7:0] remoteBTemp,
  input wire [7:0] remoteBLimit,
  input wire [7:0] cpuTemp,
  input wire [7:0] cpuControlLimit,
  output reg overtemp_signal,
  output reg tempFormatSelect,
  output reg offsetRangeSelect,
  output reg [1:0] alertPinFunction,
  output reg [1:0] tachPinFunction,
  output reg alertPinIsOvertemp,
  output reg tachPinIsOvertemp,
  output reg alertPinIsGeneralIo,
  output reg tachPinIsFanSpeed,
  output reg [4:0] attenBypass
);

  // ********************************************************
  // register file
  // ********************************************************
  reg [7:0] fmtPin_reg;
  reg [7:0] muxAtt_reg;
  reg [7:0] rdData_next;
  wire fmtHit;
  wire muxHit;
  wire wrFmt;
  wire wrMux;

  // ********************************************************
  // address decode and write gating
  // ********************************************************
  assign fmtHit = (regAddr == `TCR_FMT_PIN_ADDR);
  assign muxHit = (regAddr == `TCR_MUX_ATT_ADDR);
  assign wrFmt = regWrEn && !configLock && fmtHit;
  assign wrMux = regWrEn && !configLock && muxHit;

  // temperature format and pin configuration byte
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      fmtPin_reg <= `TCR_FMT_PIN_RESET;
    end else if (wrFmt) begin
      fmtPin_reg <= regWrData;
    end
  end

  // pin mux and attenuator bypass byte
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      muxAtt_reg <= `TCR_MUX_ATT_RESET;
    end else if (wrMux) begin
      muxAtt_reg <= regWrData;
    end
  end

  // ********************************************************
  // read port
  // ********************************************************
  always @* begin
    rdData_next = regRdData;
    if (regRdEn) begin
      case (regAddr)
        `TCR_FMT_PIN_ADDR: rdData_next = fmtPin_reg;
        `TCR_MUX_ATT_ADDR: rdData_next = muxAtt_reg;
        default: rdData_next = 8'h00;
      endcase
    end
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      regRdData <= 8'h00;
    end else begin
      regRdData <= rdData_next;
    end
  end

  // ********************************************************
  // temperature comparison
  // ********************************************************
  // map a raw code to an ordered unsigned scale for the active format
  function [7:0] tcrOrder;
    input [7:0] code;
    input twos;
    begin
      if (twos) begin
        tcrOrder = code ^ 8'h80;
      end else begin
        tcrOrder = code;
      end
    end
  endfunction

  // limit code that means "channel switched off" in the active format
  function tcrIsOff;
    input [7:0] lim;
    input twos;
    begin
      if (twos) begin
        tcrIsOff = (lim == `TCR_DIS_TWOS);
      end else begin
        tcrIsOff = (lim == `TCR_DIS_OFS64);
      end
    end
  endfunction

  wire twosMode;
  wire [3:0] chanEn;
  wire [3:0] chanHit;
  wire [3:0] chanOff;
  wire [7:0] chTemp [0:3];
  wire [7:0] chLimit [0:3];
  wire anyHit;

  // ********************************************************
  // channel map
  // ********************************************************
  assign twosMode = fmtPin_reg[`TCR_FMT_BIT];
  assign chanEn[0] = fmtPin_reg[`TCR_CPU_EN_BIT];
  assign chanEn[1] = fmtPin_reg[`TCR_REMA_EN_BIT];
  assign chanEn[2] = fmtPin_reg[`TCR_LOCAL_EN_BIT];
  assign chanEn[3] = fmtPin_reg[`TCR_REMB_EN_BIT];
  assign chTemp[0] = cpuTemp;
  assign chTemp[1] = remoteATemp;
  assign chTemp[2] = localTemp;
  assign chTemp[3] = remoteBTemp;
  assign chLimit[0] = cpuControlLimit;
  assign chLimit[1] = remoteALimit;
  assign chLimit[2] = localLimit;
  assign chLimit[3] = remoteBLimit;

  // cpu reading is always two's complement; only -128 turns it off
  assign chanOff[0] = (cpuControlLimit == `TCR_DIS_TWOS);
  wire [7:0] cpuTempOrd;
  wire [7:0] cpuLimitOrd;
  assign cpuTempOrd = tcrOrder(cpuTemp, 1'b1);
  assign cpuLimitOrd = tcrOrder(cpuControlLimit, 1'b1);
  assign chanHit[0] = (cpuTempOrd > cpuLimitOrd);

  // ********************************************************
  // channel compare
  // ********************************************************
  genvar gi;
  generate
    for (gi = 1; gi < 4; gi = gi + 1) begin : gChan
      assign chanOff[gi] = tcrIsOff(chLimit[gi], twosMode);
      assign chanHit[gi] = tcrOrder(chTemp[gi], twosMode) > tcrOrder(chLimit[gi], twosMode);
    end
  endgenerate

  // disabled channels contribute nothing, so they only leave the pin as input
  wire [3:0] liveHit;
  assign liveHit = chanEn & chanHit & ~chanOff;
  assign anyHit = (|liveHit) && overtempPinBidir;

  // ********************************************************
  // outputs
  // ********************************************************
  // true when a two-bit pin function field holds the given code
  function tcrFnIs;
    input [1:0] field;
    input [1:0] code;
    begin
      tcrFnIs = (field == code);
    end
  endfunction

  wire [1:0] alertFn;
  wire [1:0] tachFn;
  wire globalDisable;
  wire [4:0] bypassBits;

  assign alertFn = fmtPin_reg[`TCR_ALERTF_LO+1:`TCR_ALERTF_LO];
  assign tachFn = muxAtt_reg[`TCR_TACHF_LO+1:`TCR_TACHF_LO];
  assign globalDisable = muxAtt_reg[`TCR_GDIS_BIT];
  // order: termination, 2.5 V, core, 5 V, 12 V
  assign bypassBits = muxAtt_reg[`TCR_BYP_LO+4:`TCR_BYP_LO];

  // ********************************************************
  // next values of the output flops
  // ********************************************************
  wire overtempSignal_next;
  wire tempFormatSelect_next;
  wire offsetRangeSelect_next;
  wire [1:0] alertPinFunction_next;
  wire [1:0] tachPinFunction_next;
  wire alertPinIsOvertemp_next;
  wire alertPinIsGeneralIo_next;
  wire tachPinIsOvertemp_next;
  wire tachPinIsFanSpeed_next;
  wire [4:0] attenBypass_next;

  assign overtempSignal_next = anyHit && !globalDisable;
  assign tempFormatSelect_next = fmtPin_reg[`TCR_FMT_BIT];
  // applies to remote and internal offsets; cpu offset ignores it
  assign offsetRangeSelect_next = fmtPin_reg[`TCR_OFSR_BIT];
  assign alertPinFunction_next = alertFn;
  assign tachPinFunction_next = tachFn;
  assign alertPinIsOvertemp_next = tcrFnIs(alertFn, `TCR_FN_OVT_A);
  assign alertPinIsGeneralIo_next = tcrFnIs(alertFn, `TCR_FN_GPIO_A);
  assign tachPinIsOvertemp_next = tcrFnIs(tachFn, `TCR_FN_OVT_B);
  assign tachPinIsFanSpeed_next = tcrFnIs(tachFn, `TCR_FN_TACH_B);
  assign attenBypass_next = bypassBits;

  // ********************************************************
  // overtemperature output
  // ********************************************************
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      overtemp_signal <= 1'b0;
    end else begin
      overtemp_signal <= overtempSignal_next;
    end
  end

  // ********************************************************
  // format and offset range copies
  // ********************************************************
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tempFormatSelect <= 1'b0;
    end else begin
      tempFormatSelect <= tempFormatSelect_next;
    end
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      offsetRangeSelect <= 1'b0;
    end else begin
      offsetRangeSelect <= offsetRangeSelect_next;
    end
  end

  // ********************************************************
  // pin function fields
  // ********************************************************
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      alertPinFunction <= 2'b00;
    end else begin
      alertPinFunction <= alertPinFunction_next;
    end
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tachPinFunction <= 2'b00;
    end else begin
      tachPinFunction <= tachPinFunction_next;
    end
  end

  // ********************************************************
  // pin function decodes
  // ********************************************************
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      alertPinIsOvertemp <= 1'b0;
    end else begin
      alertPinIsOvertemp <= alertPinIsOvertemp_next;
    end
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      alertPinIsGeneralIo <= 1'b0;
    end else begin
      alertPinIsGeneralIo <= alertPinIsGeneralIo_next;
    end
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tachPinIsOvertemp <= 1'b0;
    end else begin
      tachPinIsOvertemp <= tachPinIsOvertemp_next;
    end
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tachPinIsFanSpeed <= 1'b0;
    end else begin
      tachPinIsFanSpeed <= tachPinIsFanSpeed_next;
    end
  end

  // ********************************************************
  // attenuator bypass
  // ********************************************************
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      attenBypass <= 5'h00;
    end else begin
      attenBypass <= attenBypass_next;
    end
  end

endmodule

// file: tcr_config_regs_monitor.sv
/*
  concurrent checks on the configuration register pair ports.
  assumes it is bound onto tcr_config_regs and sees only its ports.
*/
`timescale 1ns/100ps
module tcr_config_regs_monitor #(
  parameter ADDR_WIDTH = 8
) (
  input wire ref_clk,
  input wire rst_n,
  input wire [ADDR_WIDTH-1:0] regAddr,
  input wire [7:0] regWrData,
  input wire regWrEn,
  input wire regRdEn,
  input wire [7:0] regRdData,
  input wire configLock,
  input wire overtempPinBidir,
  input wire overtemp_signal,
  input wire tempFormatSelect,
  input wire offsetRangeSelect,
  input wire [1:0] alertPinFunction,
  input wire [1:0] tachPinFunction,
  input wire alertPinIsOvertemp,
  input wire tachPinIsOvertemp,
  input wire alertPinIsGeneralIo,
  input wire tachPinIsFanSpeed,
  input wire [4:0] attenBypass
);
  // ****************
  // checks
  // ****************
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire [3:0] fmtBits = {alertPinFunction, offsetRangeSelect, tempFormatSelect};
  wire [6:0] muxBits = {attenBypass, tachPinFunction};
  wire [6:0] wrMux = {regWrData[7:3], regWrData[1:0]};
  wire [3:0] wrFmt = regWrData[3:0];
  sequence wrOpen(a); regWrEn && !configLock && regAddr == a; endsequence
  sequence rdOf(a); regRdEn && regAddr == a; endsequence
  a_lock_holds_cfg:
    assert property (regWrEn && configLock |-> ##2 $stable({fmtBits, muxBits}))
    else $error("locked write took effect");
  a_wr_fmt_pin:
    assert property (wrOpen(8'h7C) |-> ##2 fmtBits == $past(wrFmt, 2)) else $error("fmt write");
  a_wr_mux_att:
    assert property (wrOpen(8'h7D) |-> ##2 muxBits == $past(wrMux, 2)) else $error("mux write");
  a_rd_fmt_pin:
    assert property (rdOf(8'h7C) |=> regRdData[3:0] == fmtBits) else $error("fmt read");
  a_rd_mux_att:
    assert property (rdOf(8'h7D) |=> {regRdData[7:3], regRdData[1:0]} == muxBits)
    else $error("mux read");
  a_alert_fn_decode:
    assert property (alertPinIsOvertemp == (alertPinFunction == 2'b01)
      && alertPinIsGeneralIo == (alertPinFunction == 2'b10)) else $error("alert decode");
  a_tach_fn_decode:
    assert property ($past(rst_n) |-> tachPinIsOvertemp == (tachPinFunction == 2'b01)
      && tachPinIsFanSpeed == (tachPinFunction == 2'b00)) else $error("tach decode");
  a_unidir_quiet:
    assert property (!$past(overtempPinBidir) |-> !overtemp_signal) else $error("drove pin");
endmodule

// file: tb_tcr_config_regs.sv
/*
  self-checking bench for the configuration register pair.
  assumes tcr_config_regs and its monitor are compiled alongside.
*/
`timescale 1ns/100ps
module tb_tcr_config_regs;
  reg ref_clk, rst_n, regWrEn, regRdEn, configLock, overtempPinBidir, rdLate, otProbe;
  reg [7:0] regAddr, regWrData, remoteATemp, remoteALimit, localTemp, localLimit;
  reg [7:0] remoteBTemp, remoteBLimit, cpuTemp, cpuControlLimit, d;
  wire [7:0] regRdData;
  wire overtemp_signal, tempFormatSelect, offsetRangeSelect, alertPinIsOvertemp;
  wire tachPinIsOvertemp, alertPinIsGeneralIo, tachPinIsFanSpeed;
  wire [1:0] alertPinFunction, tachPinFunction;
  wire [4:0] attenBypass;
  integer num_errors = 0, comparisons = 0, seed = 21, cycles = 0, i;
  logic [7:0] rdQ[$];
  logic otQ[$];
  tcr_config_regs DUT (.ref_clk, .rst_n, .regAddr, .regWrData, .regWrEn, .regRdEn,
    .regRdData, .configLock, .overtempPinBidir, .remoteATemp, .remoteALimit, .localTemp,
    .localLimit, .remoteBTemp, .remoteBLimit, .cpuTemp, .cpuControlLimit, .overtemp_signal,
    .tempFormatSelect, .offsetRangeSelect, .alertPinFunction, .tachPinFunction,
    .alertPinIsOvertemp, .tachPinIsOvertemp, .alertPinIsGeneralIo, .tachPinIsFanSpeed,
    .attenBypass);
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  // ****************
  // tasks
  // ****************
  task chkRd(input [7:0] got, input [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task chkOt(input got, input exp);
    chkRd({7'h0, got}, {7'h0, exp});
  endtask
  task tally_and_finish;
    $display("comparisons %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task wr(input [7:0] a, input [7:0] v);
    @(posedge ref_clk) begin regAddr <= a; regWrData <= v; regWrEn <= 1'b1; end
    @(posedge ref_clk) regWrEn <= 1'b0;
  endtask
  task rd(input [7:0] a, input [7:0] e);
    @(posedge ref_clk) begin regAddr <= a; regRdEn <= 1'b1; rdQ.push_back(e); end
    @(posedge ref_clk) regRdEn <= 1'b0;
  endtask
  task ot(input e);
    repeat (3) @(posedge ref_clk);
    otQ.push_back(e);
    otProbe <= 1'b1;
    @(posedge ref_clk) otProbe <= 1'b0;
  endtask
  // ****************
  // result watcher and stimulus
  // ****************
  always @(posedge ref_clk) begin
    rdLate <= regRdEn;
    cycles++;
    if (cycles > 3000) begin num_errors++; tally_and_finish; end
  end
  always @(negedge ref_clk) begin
    if (rdLate) chkRd(regRdData, rdQ.pop_front());
    if (otProbe) chkOt(overtemp_signal, otQ.pop_front());
  end
  initial begin
    {rst_n, regWrEn, regRdEn, configLock, overtempPinBidir, rdLate, otProbe} = 7'h00;
    {regAddr, regWrData, remoteALimit, localLimit, remoteBLimit, cpuControlLimit} = 48'h0;
    {remoteATemp, localTemp, remoteBTemp, cpuTemp, d} = 40'h0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(8'h7C, 8'h05);
    rd(8'h7D, 8'h00);
    rd(8'h7E, 8'h00);
    for (i = 0; i < 4; i++) begin
      d = $random(seed);
      wr(8'h7D, d); rd(8'h7D, d);
      wr(8'h7C, d); rd(8'h7C, d);
    end
    configLock <= 1'b1;
    wr(8'h7C, ~d); rd(8'h7C, d);
    wr(8'h7D, ~d); rd(8'h7D, d);
    configLock <= 1'b0;
    $display("register tests done");
    overtempPinBidir <= 1'b1;
    {remoteATemp, localTemp, remoteBTemp, cpuTemp} <= {4{8'h30}};
    {remoteALimit, localLimit, remoteBLimit, cpuControlLimit} <= {4{8'h20}};
    wr(8'h7D, 8'h00);
    for (i = 0; i < 4; i++) begin
      wr(8'h7C, (8'h10 << i) | 8'h01); ot(1'b1);
    end
    wr(8'h7C, 8'h01); ot(1'b0);
    {remoteALimit, localLimit, remoteBLimit, cpuControlLimit} <= {4{8'h80}};
    wr(8'h7C, 8'hF1); ot(1'b0);
    {remoteALimit, localLimit, remoteBLimit} <= 24'h0;
    wr(8'h7C, 8'hF0); ot(1'b0);
    {remoteALimit, remoteATemp} <= {8'h20, 8'hF0};
    wr(8'h7C, 8'h21); ot(1'b0);
    wr(8'h7C, 8'h20); ot(1'b1);
    wr(8'h7D, 8'h04); ot(1'b0);
    wr(8'h7D, 8'h00); overtempPinBidir <= 1'b0; ot(1'b0);
    $display("overtemp tests done");
    tally_and_finish;
  end
endmodule
bind tcr_config_regs tcr_config_regs_monitor #(.ADDR_WIDTH(ADDR_WIDTH)) uMon (.ref_clk,
  .rst_n, .regAddr, .regWrData, .regWrEn, .regRdEn, .regRdData, .configLock,
  .overtempPinBidir, .overtemp_signal, .tempFormatSelect, .offsetRangeSelect,
  .alertPinFunction, .tachPinFunction, .alertPinIsOvertemp, .tachPinIsOvertemp,
  .alertPinIsGeneralIo, .tachPinIsFanSpeed, .attenBypass);
